//--- logic/ldev_routing.sv
// Per logical device configuration, I/O decode, interrupt and DMA routing.
`timescale 1ns/10ps
module ldev_routing
	import ldev_routing_pkg::*;
#(
	parameter int IRQ_LINES = 16,
	parameter int DMA_CHANNELS = 3
) (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic [7:0] CFG_ADDR_I,
	input wire logic [7:0] CFG_WDATA_I,
	input wire logic CFG_WR_I,
	input wire logic CFG_RD_I,
	output logic [7:0] CFG_RDATA_O,
	input wire logic [15:0] IO_ADDR_I,
	input wire logic IO_CYC_I,
	output logic FLOPPY_SEL_O,
	output logic PAR_SEL_O,
	output logic PAR_ECP_SEL_O,
	output logic SER1_SEL_O,
	output logic SER2_SEL_O,
	output logic IR_SEL_O,
	output logic KBD_DATA_SEL_O,
	output logic KBD_CMD_SEL_O,
	output logic [2:0] IO_OFFSET_O,
	input wire logic FLOPPY_IRQ_I,
	input wire logic FLOPPY_DMA_GATE_I,
	input wire logic FLOPPY_DREQ_I,
	input wire logic PAR_IRQ_I,
	input wire logic PARALLEL_IRQ_GATE_I,
	input wire logic [2:0] PAR_ECR_MODE_I,
	input wire logic ECP_SERVICE_FLAG_I,
	input wire logic ECP_DMA_GATE_I,
	input wire logic PAR_DREQ_I,
	input wire logic SER1_IRQ_I,
	input wire logic [3:0] SER1_IRQ_ENABLE_I,
	input wire logic SER1_AUX_OUTPUT_TWO_I,
	input wire logic SER2_IRQ_I,
	input wire logic [3:0] SER2_IRQ_ENABLE_I,
	input wire logic SER2_AUX_OUTPUT_TWO_I,
	input wire logic SER2_DMA_GATE_I,
	input wire logic SER2_DREQ_I,
	input wire logic KBD_IRQ_I,
	input wire logic SERIAL_IRQ_MODE_I,
	input wire logic SMI_REQ_I,
	input wire logic SMI_EN_I,
	output logic [15:0] IRQ_O,
	output logic [15:0] IRQ_OE_O,
	output logic SYS_MGMT_IRQ_N_O,
	output logic [2:0] DMA_REQUEST_PIN_O,
	output logic [2:0] DMA_REQUEST_PIN_OE_O,
	input wire logic [2:0] DMA_ACK_N_I,
	output logic FLOPPY_DACK_O,
	output logic PAR_DACK_O,
	output logic SER2_DACK_O
);
	initial begin
		if (IRQ_LINES != 16) begin
			$error("ldev_routing: IRQ_LINES must be 16");
		end
		if (DMA_CHANNELS != 3) begin
			$error("ldev_routing: DMA_CHANNELS must be 3");
		end
	end

	typedef struct packed {
		logic [7:0] ldn;
		logic [NUM_SLOTS-1:0] act;
		logic [NUM_SLOTS-1:0][15:0] base0;
		logic [15:0] base1;
		logic [NUM_SLOTS-1:0][3:0] irq_sel;
		logic [NUM_SLOTS-1:0][2:0] dma_sel;
		logic [7:0] rdata;
		logic floppy_sel;
		logic par_sel;
		logic par_ecp_sel;
		logic ser1_sel;
		logic ser2_sel;
		logic ir_sel;
		logic kbd_data_sel;
		logic kbd_cmd_sel;
		logic [2:0] io_off;
		logic [15:0] irq_lvl;
		logic [15:0] irq_oe;
		logic smi_n;
		logic [2:0] dreq;
		logic [2:0] dreq_oe;
		logic floppy_dack;
		logic par_dack;
		logic ser2_dack;
	} state_t;

	state_t st_r;
	state_t st_nxt;

	logic floppy_valid;
	logic floppy_hit;
	logic par_valid;
	logic par_aligned8;
	logic par_hit;
	logic par_ecp_hit;
	logic ser1_valid;
	logic ser1_hit;
	logic ser2_valid;
	logic ser2_hit;
	logic ir_valid;
	logic ir_hit;
	logic [NUM_SLOTS-1:0] base_ok;
	logic [NUM_SLOTS-1:0] irq_req;
	logic [NUM_SLOTS-1:0] irq_gate;
	logic [2:0] dma_dreq [NUM_SLOTS];
	logic [NUM_SLOTS-1:0] dma_gate;
	logic [NUM_SLOTS-1:0] unit_dreq;
	logic par_ecp_class;
	logic [2:0] cur_slot;

	base_window_decode #(.MAX_BASE(BASE_MAX_8), .MIN_ALIGN(3)) u_floppy_dec (
		.base_i(st_r.base0[SLOT_FLOPPY]),
		.addr_i(IO_ADDR_I[11:0]),
		.enable_i(IO_CYC_I && st_r.act[SLOT_FLOPPY]),
		.valid_o(floppy_valid),
		.aligned8_o(),
		.hit_o(floppy_hit),
		.ecp_hit_o()
	);

	base_window_decode #(.MAX_BASE(BASE_MAX_4), .MIN_ALIGN(2)) u_par_dec (
		.base_i(st_r.base0[SLOT_PARALLEL]),
		.addr_i(IO_ADDR_I[11:0]),
		.enable_i(IO_CYC_I && st_r.act[SLOT_PARALLEL]),
		.valid_o(par_valid),
		.aligned8_o(par_aligned8),
		.hit_o(par_hit),
		.ecp_hit_o(par_ecp_hit)
	);

	base_window_decode #(.MAX_BASE(BASE_MAX_8), .MIN_ALIGN(3)) u_ser1_dec (
		.base_i(st_r.base0[SLOT_SERIAL1]),
		.addr_i(IO_ADDR_I[11:0]),
		.enable_i(IO_CYC_I && st_r.act[SLOT_SERIAL1]),
		.valid_o(ser1_valid),
		.aligned8_o(),
		.hit_o(ser1_hit),
		.ecp_hit_o()
	);

	base_window_decode #(.MAX_BASE(BASE_MAX_8), .MIN_ALIGN(3)) u_ser2_dec (
		.base_i(st_r.base0[SLOT_SERIAL2]),
		.addr_i(IO_ADDR_I[11:0]),
		.enable_i(IO_CYC_I && st_r.act[SLOT_SERIAL2]),
		.valid_o(ser2_valid),
		.aligned8_o(),
		.hit_o(ser2_hit),
		.ecp_hit_o()
	);

	base_window_decode #(.MAX_BASE(BASE_MAX_8), .MIN_ALIGN(3)) u_ir_dec (
		.base_i(st_r.base1),
		.addr_i(IO_ADDR_I[11:0]),
		.enable_i(IO_CYC_I && st_r.act[SLOT_SERIAL2]),
		.valid_o(ir_valid),
		.aligned8_o(),
		.hit_o(ir_hit),
		.ecp_hit_o()
	);

	// The parallel unit only exists on the bus when its own base is legal.
	assign base_ok = {1'b1, ser2_valid, ser1_valid, par_valid, floppy_valid};
	assign cur_slot = ldn_slot(st_r.ldn);
	assign par_ecp_class = (PAR_ECR_MODE_I == ECR_MODE_FIFO) || (PAR_ECR_MODE_I == ECR_MODE_ECP)
		|| (PAR_ECR_MODE_I == ECR_MODE_TEST);

	// Unit gates decide whether a pin is driven at all, not only its level.
	always_comb begin
		irq_req = {KBD_IRQ_I, SER2_IRQ_I, SER1_IRQ_I, PAR_IRQ_I, FLOPPY_IRQ_I};
		irq_gate[SLOT_FLOPPY] = FLOPPY_DMA_GATE_I;
		irq_gate[SLOT_PARALLEL] = PARALLEL_IRQ_GATE_I && !(par_ecp_class && ECP_SERVICE_FLAG_I);
		irq_gate[SLOT_SERIAL1] = (|SER1_IRQ_ENABLE_I) && SER1_AUX_OUTPUT_TWO_I;
		irq_gate[SLOT_SERIAL2] = (|SER2_IRQ_ENABLE_I) && SER2_AUX_OUTPUT_TWO_I;
		irq_gate[SLOT_KEYBOARD] = 1'b1;
		dma_gate = '0;
		dma_gate[SLOT_FLOPPY] = FLOPPY_DMA_GATE_I;
		dma_gate[SLOT_PARALLEL] = ECP_DMA_GATE_I;
		dma_gate[SLOT_SERIAL2] = SER2_DMA_GATE_I;
		unit_dreq = '0;
		unit_dreq[SLOT_FLOPPY] = FLOPPY_DREQ_I;
		unit_dreq[SLOT_PARALLEL] = PAR_DREQ_I;
		unit_dreq[SLOT_SERIAL2] = SER2_DREQ_I;
	end

	always_comb begin
		for (int s = 0; s < NUM_SLOTS; s++) begin
			dma_dreq[s] = 3'h0;
			if (st_r.dma_sel[s] >= DMA_FIRST && st_r.dma_sel[s] <= DMA_LAST) begin
				dma_dreq[s] = 3'h1 << (st_r.dma_sel[s] - DMA_FIRST);
			end
		end
	end

	always_comb begin
		logic [15:0] lvl;
		logic [15:0] oe;
		logic [2:0] dreq;
		logic [2:0] dreq_oe;
		logic [2:0] chan_hot;
		lvl = '0;
		oe = '0;
		dreq = '0;
		dreq_oe = '0;
		chan_hot = '0;
		st_nxt = st_r;

		// Configuration writes land in the slot picked by the device number.
		if (CFG_WR_I) begin
			if (CFG_ADDR_I == IDX_LDN) begin
				st_nxt.ldn = CFG_WDATA_I;
			end else if (cur_slot != SLOT_NONE) begin
				case (CFG_ADDR_I)
					IDX_ACTIVATE: st_nxt.act[cur_slot] = CFG_WDATA_I[0];
					IDX_BASE0_HI: begin
						if (cur_slot != SLOT_KEYBOARD) begin
							st_nxt.base0[cur_slot][15:8] = CFG_WDATA_I;
						end
					end
					IDX_BASE0_LO: begin
						if (cur_slot != SLOT_KEYBOARD) begin
							st_nxt.base0[cur_slot][7:0] = CFG_WDATA_I;
						end
					end
					IDX_BASE1_HI: begin
						if (cur_slot == SLOT_SERIAL2) begin
							st_nxt.base1[15:8] = CFG_WDATA_I;
						end
					end
					IDX_BASE1_LO: begin
						if (cur_slot == SLOT_SERIAL2) begin
							st_nxt.base1[7:0] = CFG_WDATA_I;
						end
					end
					IDX_IRQ_SEL: st_nxt.irq_sel[cur_slot] = CFG_WDATA_I[3:0];
					IDX_DMA_SEL: begin
						if (has_dma(cur_slot)) begin
							st_nxt.dma_sel[cur_slot] = CFG_WDATA_I[2:0];
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Read data stand only in the cycle after the strobe.
		st_nxt.rdata = 8'h00;
		if (CFG_RD_I) begin
			if (CFG_ADDR_I == IDX_LDN) begin
				st_nxt.rdata = st_r.ldn;
			end else if (cur_slot != SLOT_NONE) begin
				case (CFG_ADDR_I)
					IDX_ACTIVATE: st_nxt.rdata = {7'h00, st_r.act[cur_slot]};
					IDX_BASE0_HI: st_nxt.rdata = st_r.base0[cur_slot][15:8];
					IDX_BASE0_LO: st_nxt.rdata = st_r.base0[cur_slot][7:0];
					IDX_BASE1_HI: st_nxt.rdata = (cur_slot == SLOT_SERIAL2) ? st_r.base1[15:8] : 8'h00;
					IDX_BASE1_LO: st_nxt.rdata = (cur_slot == SLOT_SERIAL2) ? st_r.base1[7:0] : 8'h00;
					IDX_IRQ_SEL: st_nxt.rdata = {4'h0, st_r.irq_sel[cur_slot]};
					IDX_DMA_SEL: st_nxt.rdata = {5'h00, st_r.dma_sel[cur_slot]};
					default: st_nxt.rdata = 8'h00;
				endcase
			end
		end

		// Host I/O decode; chip selects follow the address by one cycle.
		st_nxt.floppy_sel = floppy_hit;
		st_nxt.par_sel = par_hit;
		st_nxt.par_ecp_sel = par_ecp_hit;
		st_nxt.ser1_sel = ser1_hit;
		st_nxt.ser2_sel = ser2_hit;
		st_nxt.ir_sel = ir_hit;
		st_nxt.kbd_data_sel = IO_CYC_I && st_r.act[SLOT_KEYBOARD] && (IO_ADDR_I[11:0] == KBD_DATA_ADDR);
		st_nxt.kbd_cmd_sel = IO_CYC_I && st_r.act[SLOT_KEYBOARD] && (IO_ADDR_I[11:0] == KBD_CMD_ADDR);
		st_nxt.io_off = IO_ADDR_I[2:0];

		// Each pin is driven only while some live, gated device claims it.
		for (int s = 0; s < NUM_SLOTS; s++) begin
			if (st_r.act[s] && base_ok[s] && st_r.irq_sel[s] != IRQ_SEL_RESET && irq_gate[s]) begin
				oe[st_r.irq_sel[s]] = 1'b1;
				if (irq_req[s]) begin
					lvl[st_r.irq_sel[s]] = 1'b1;
				end
			end
			if (st_r.act[s] && base_ok[s] && dma_gate[s]) begin
				dreq_oe = dreq_oe | dma_dreq[s];
				if (unit_dreq[s]) begin
					dreq = dreq | dma_dreq[s];
				end
			end
		end
		// Pin mode lacks the encoder for levels other than 3-7 and 10-12, so those are never driven.
		if (!SERIAL_IRQ_MODE_I) begin
			oe = oe & PIN_MODE_IRQ_MASK;
		end
		st_nxt.irq_oe = oe;
		st_nxt.irq_lvl = lvl & oe;
		st_nxt.smi_n = !(SMI_REQ_I && SMI_EN_I);
		st_nxt.dreq = dreq;
		st_nxt.dreq_oe = dreq_oe;

		chan_hot = ~DMA_ACK_N_I;
		st_nxt.floppy_dack = st_r.act[SLOT_FLOPPY] && floppy_valid && dma_gate[SLOT_FLOPPY]
			&& |(dma_dreq[SLOT_FLOPPY] & chan_hot);
		st_nxt.par_dack = st_r.act[SLOT_PARALLEL] && par_valid && dma_gate[SLOT_PARALLEL]
			&& |(dma_dreq[SLOT_PARALLEL] & chan_hot);
		st_nxt.ser2_dack = st_r.act[SLOT_SERIAL2] && ser2_valid && dma_gate[SLOT_SERIAL2]
			&& |(dma_dreq[SLOT_SERIAL2] & chan_hot);
	end

	always_ff @(posedge CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			st_r <= '0;
			st_r.ldn <= LDN_RESET;
			for (int s = 0; s < NUM_SLOTS; s++) begin
				st_r.base0[s] <= BASE_RESET;
				st_r.irq_sel[s] <= IRQ_SEL_RESET;
				st_r.dma_sel[s] <= has_dma(3'(s)) ? DMA_SEL_RESET : 3'h0;
			end
			st_r.base1 <= BASE_RESET;
			st_r.smi_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign CFG_RDATA_O = st_r.rdata;
	assign FLOPPY_SEL_O = st_r.floppy_sel;
	assign PAR_SEL_O = st_r.par_sel;
	assign PAR_ECP_SEL_O = st_r.par_ecp_sel;
	assign SER1_SEL_O = st_r.ser1_sel;
	assign SER2_SEL_O = st_r.ser2_sel;
	assign IR_SEL_O = st_r.ir_sel;
	assign KBD_DATA_SEL_O = st_r.kbd_data_sel;
	assign KBD_CMD_SEL_O = st_r.kbd_cmd_sel;
	assign IO_OFFSET_O = st_r.io_off;
	assign IRQ_O = st_r.irq_lvl;
	assign IRQ_OE_O = st_r.irq_oe;
	assign SYS_MGMT_IRQ_N_O = st_r.smi_n;
	assign DMA_REQUEST_PIN_O = st_r.dreq;
	assign DMA_REQUEST_PIN_OE_O = st_r.dreq_oe;
	assign FLOPPY_DACK_O = st_r.floppy_dack;
	assign PAR_DACK_O = st_r.par_dack;
	assign SER2_DACK_O = st_r.ser2_dack;
endmodule : ldev_routing

//--- shared/ldev_routing_pkg.sv
// Constants and helpers shared by the logical device routing bank.
package ldev_routing_pkg;

	localparam logic [7:0] IDX_LDN = 8'h07;
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_BASE0_HI = 8'h60;
	localparam logic [7:0] IDX_BASE0_LO = 8'h61;
	localparam logic [7:0] IDX_BASE1_HI = 8'h62;
	localparam logic [7:0] IDX_BASE1_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
	localparam logic [7:0] IDX_DMA_SEL = 8'h74;

	localparam logic [7:0] LDN_FLOPPY = 8'h00;
	localparam logic [7:0] LDN_PARALLEL = 8'h03;
	localparam logic [7:0] LDN_SERIAL1 = 8'h04;
	localparam logic [7:0] LDN_SERIAL2 = 8'h05;
	localparam logic [7:0] LDN_KEYBOARD = 8'h07;

	localparam int NUM_SLOTS = 5;
	localparam logic [2:0] SLOT_FLOPPY = 3'h0;
	localparam logic [2:0] SLOT_PARALLEL = 3'h1;
	localparam logic [2:0] SLOT_SERIAL1 = 3'h2;
	localparam logic [2:0] SLOT_SERIAL2 = 3'h3;
	localparam logic [2:0] SLOT_KEYBOARD = 3'h4;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	localparam logic [15:0] BASE_MIN = 16'h0100;
	localparam logic [15:0] BASE_MAX_8 = 16'h0FF8;
	localparam logic [15:0] BASE_MAX_4 = 16'h0FFC;
	localparam logic [11:0] KBD_DATA_ADDR = 12'h060;
	localparam logic [11:0] KBD_CMD_ADDR = 12'h064;
	localparam logic [9:0] ECP_WORD_OFFSET = 10'h100;
	localparam logic [1:0] ECP_LAST_OFF = 2'h2;
	localparam logic [1:0] PAR_4B_LAST_OFF = 2'h2;

	localparam logic [7:0] LDN_RESET = 8'h00;
	localparam logic [15:0] BASE_RESET = 16'h0000;
	localparam logic [3:0] IRQ_SEL_RESET = 4'h0;
	localparam logic [2:0] DMA_SEL_RESET = 3'h4;
	localparam logic [2:0] DMA_FIRST = 3'h1;
	localparam logic [2:0] DMA_LAST = 3'h3;

	localparam logic [15:0] PIN_MODE_IRQ_MASK = 16'h1CF8;

	localparam logic [2:0] ECR_MODE_FIFO = 3'h2;
	localparam logic [2:0] ECR_MODE_ECP = 3'h3;
	localparam logic [2:0] ECR_MODE_TEST = 3'h6;

	// Maps a logical device number onto an internal storage slot.
	function automatic logic [2:0] ldn_slot(input logic [7:0] ldn);
		case (ldn)
			LDN_FLOPPY: ldn_slot = SLOT_FLOPPY;
			LDN_PARALLEL: ldn_slot = SLOT_PARALLEL;
			LDN_SERIAL1: ldn_slot = SLOT_SERIAL1;
			LDN_SERIAL2: ldn_slot = SLOT_SERIAL2;
			LDN_KEYBOARD: ldn_slot = SLOT_KEYBOARD;
			default: ldn_slot = SLOT_NONE;
		endcase
	endfunction : ldn_slot

	// True for the slots that own a DMA channel select register.
	function automatic logic has_dma(input logic [2:0] slot);
		has_dma = (slot == SLOT_FLOPPY) || (slot == SLOT_PARALLEL) || (slot == SLOT_SERIAL2);
	endfunction : has_dma

endpackage : ldev_routing_pkg

//--- logic/base_window_decode.sv
// Range check and address match for one relocatable I/O base.
`timescale 1ns/10ps
module base_window_decode
	import ldev_routing_pkg::*;
#(
	parameter logic [15:0] MAX_BASE = 16'h0FF8,
	parameter int MIN_ALIGN = 3
) (
	input wire logic [15:0] base_i,
	input wire logic [11:0] addr_i,
	input wire logic enable_i,
	output logic valid_o,
	output logic aligned8_o,
	output logic hit_o,
	output logic ecp_hit_o
);
	initial begin
		if (MIN_ALIGN != 2 && MIN_ALIGN != 3) begin
			$error("base_window_decode: MIN_ALIGN must be 2 or 3");
		end
	end

	logic [1:0] low_mask;
	logic [9:0] ecp_word;

	assign low_mask = (MIN_ALIGN == 3) ? 2'h3 : 2'h1;
	assign aligned8_o = (base_i[2:0] == 3'h0);
	assign valid_o = (base_i >= BASE_MIN) && (base_i <= MAX_BASE) && ((base_i[2:1] & low_mask) == 2'h0) && (base_i[0] == 1'b0);
	assign ecp_word = base_i[11:2] + ECP_WORD_OFFSET;

	always_comb begin
		hit_o = 1'b0;
		ecp_hit_o = 1'b0;
		if (enable_i && valid_o) begin
			if (aligned8_o) begin
				hit_o = (addr_i[11:3] == base_i[11:3]);
			end else begin
				hit_o = (addr_i[11:2] == base_i[11:2]) && (addr_i[1:0] <= PAR_4B_LAST_OFF);
			end
			ecp_hit_o = (addr_i[11:2] == ecp_word) && (addr_i[1:0] <= ECP_LAST_OFF);
		end
	end
endmodule : base_window_decode

//--- dv/ldev_routing_props.sv
// Port-level assertions for the logical device routing bank.
`timescale 1ns/10ps
module ldev_routing_props (
	input wire logic CLK_I,
	input wire logic RESET_N_I,
	input wire logic CFG_RD_I,
	input wire logic [7:0] CFG_RDATA_O,
	input wire logic [15:0] IO_ADDR_I,
	input wire logic IO_CYC_I,
	input wire logic FLOPPY_SEL_O,
	input wire logic KBD_DATA_SEL_O,
	input wire logic KBD_CMD_SEL_O,
	input wire logic [2:0] IO_OFFSET_O,
	input wire logic SERIAL_IRQ_MODE_I,
	input wire logic SMI_REQ_I,
	input wire logic SMI_EN_I,
	input wire logic [15:0] IRQ_O,
	input wire logic [15:0] IRQ_OE_O,
	input wire logic SYS_MGMT_IRQ_N_O,
	input wire logic [2:0] DMA_REQUEST_PIN_O,
	input wire logic [2:0] DMA_REQUEST_PIN_OE_O,
	input wire logic [2:0] DMA_ACK_N_I,
	input wire logic FLOPPY_DACK_O
);
	logic live_r;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESET_N_I);

	// Keeps $past from looking at inputs sampled while reset was still low.
	always_ff @(posedge CLK_I or negedge RESET_N_I)
		if (!RESET_N_I)
			live_r <= 1'b0;
		else
			live_r <= 1'b1;

	chk_mgmt_low: assert property (live_r |-> SYS_MGMT_IRQ_N_O == !$past(SMI_REQ_I && SMI_EN_I))
		else $error("management interrupt level wrong");
	chk_kbd_data_addr: assert property (KBD_DATA_SEL_O |-> $past(IO_CYC_I) && $past(IO_ADDR_I[11:0]) == 12'h060)
		else $error("keyboard data select without its address");
	chk_kbd_cmd_addr: assert property (KBD_CMD_SEL_O |-> $past(IO_CYC_I) && $past(IO_ADDR_I[11:0]) == 12'h064)
		else $error("keyboard command select without its address");
	chk_rdata_idle: assert property (live_r && !$past(CFG_RD_I) |-> CFG_RDATA_O == 8'h00)
		else $error("read data outside the read cycle");
	chk_pin_mode_mask: assert property (live_r && !$past(SERIAL_IRQ_MODE_I) |-> (IRQ_OE_O & ~16'h1CF8) == 16'h0000)
		else $error("unavailable level driven in pin mode");
	chk_irq_float: assert property (IRQ_OE_O[0] == 1'b0 && (IRQ_O & ~IRQ_OE_O) == 16'h0000)
		else $error("undriven interrupt line carries a level");
	chk_dma_float: assert property ((DMA_REQUEST_PIN_O & ~DMA_REQUEST_PIN_OE_O) == 3'h0)
		else $error("undriven request line carries a level");
	chk_dack_cause: assert property (FLOPPY_DACK_O |-> $past(DMA_ACK_N_I) != 3'h7)
		else $error("floppy acknowledge without a host acknowledge");
	chk_floppy_window: assert property (FLOPPY_SEL_O |-> IO_OFFSET_O == $past(IO_ADDR_I[2:0]) && $past(IO_ADDR_I[11:8]) != 4'h0)
		else $error("floppy select below the base range or wrong offset");
endmodule : ldev_routing_props

bind ldev_routing ldev_routing_props PROPS (.*);

//--- dv/dma_host_model.sv
// Behavioural system DMA controller answering request lines with acknowledges.
`timescale 1ns/10ps
module dma_host_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] req_i,
	input wire logic [2:0] req_oe_i,
	input wire logic [1:0] delay_i,
	output logic [2:0] ack_n_o
);
	logic toggle_r;
	logic [1:0] cnt_r;
	logic [2:0] line;

	// A released line floats; a pattern that changes every cycle stops it passing for a level.
	assign line = (req_i & req_oe_i) | (~req_oe_i & {3{toggle_r}});

	// One channel is served at a time, the lowest numbered, after delay_i cycles.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			toggle_r <= 1'b0;
			cnt_r <= 2'h0;
			ack_n_o <= 3'h7;
		end else begin
			toggle_r <= ~toggle_r;
			if (line == 3'h0) begin
				cnt_r <= 2'h0;
				ack_n_o <= 3'h7;
			end else if (cnt_r < delay_i) begin
				cnt_r <= cnt_r + 2'h1;
			end else begin
				ack_n_o <= ~(line & (~line + 3'h1));
			end
		end
	end
endmodule : dma_host_model

//--- dv/testbench.sv
// Self-checking bench for the logical device routing bank.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, a); end end
`define UNITS {FLOPPY_IRQ_I, FLOPPY_DMA_GATE_I, FLOPPY_DREQ_I, PAR_IRQ_I, PARALLEL_IRQ_GATE_I, PAR_ECR_MODE_I, ECP_SERVICE_FLAG_I, ECP_DMA_GATE_I, PAR_DREQ_I, SER1_IRQ_I, SER1_IRQ_ENABLE_I, SER1_AUX_OUTPUT_TWO_I, SER2_IRQ_I, SER2_IRQ_ENABLE_I, SER2_AUX_OUTPUT_TWO_I, SER2_DMA_GATE_I, SER2_DREQ_I, KBD_IRQ_I, SERIAL_IRQ_MODE_I, SMI_REQ_I, SMI_EN_I}
module testbench;
	logic CLK_I, RESET_N_I, CFG_WR_I, CFG_RD_I, IO_CYC_I;
	logic [7:0] CFG_ADDR_I, CFG_WDATA_I, CFG_RDATA_O, sels;
	logic [15:0] IO_ADDR_I, IRQ_O, IRQ_OE_O, e16;
	logic FLOPPY_SEL_O, PAR_SEL_O, PAR_ECP_SEL_O, SER1_SEL_O, SER2_SEL_O, IR_SEL_O;
	logic KBD_DATA_SEL_O, KBD_CMD_SEL_O, SYS_MGMT_IRQ_N_O, FLOPPY_DACK_O, PAR_DACK_O, SER2_DACK_O;
	logic [2:0] IO_OFFSET_O, PAR_ECR_MODE_I, DMA_REQUEST_PIN_O, DMA_REQUEST_PIN_OE_O, DMA_ACK_N_I;
	logic FLOPPY_IRQ_I, FLOPPY_DMA_GATE_I, FLOPPY_DREQ_I, PAR_IRQ_I, PARALLEL_IRQ_GATE_I;
	logic ECP_SERVICE_FLAG_I, ECP_DMA_GATE_I, PAR_DREQ_I, SER1_IRQ_I, SER1_AUX_OUTPUT_TWO_I;
	logic [3:0] SER1_IRQ_ENABLE_I, SER2_IRQ_ENABLE_I;
	logic SER2_IRQ_I, SER2_AUX_OUTPUT_TWO_I, SER2_DMA_GATE_I, SER2_DREQ_I, KBD_IRQ_I;
	logic SERIAL_IRQ_MODE_I, SMI_REQ_I, SMI_EN_I;
	logic [1:0] ack_delay;
	logic [7:0] dma_ldn [3] = '{8'h00, 8'h03, 8'h05};
	int n_fail, checks, cycles;

	assign sels = {FLOPPY_SEL_O, PAR_SEL_O, PAR_ECP_SEL_O, SER1_SEL_O, SER2_SEL_O, IR_SEL_O,
		KBD_DATA_SEL_O, KBD_CMD_SEL_O};

	ldev_routing DUT (.*);
	dma_host_model PARTNER (.clk_i(CLK_I), .rst_n_i(RESET_N_I), .req_i(DMA_REQUEST_PIN_O),
		.req_oe_i(DMA_REQUEST_PIN_OE_O), .delay_i(ack_delay), .ack_n_o(DMA_ACK_N_I));

	always #5 CLK_I = ~CLK_I;

	always @(posedge CLK_I) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	// Interrupt enables expected with floppy on line 6, serial one on 3, parallel on 7.
	function automatic logic [15:0] exp_oe();
		logic ecp;
		ecp = PAR_ECR_MODE_I inside {3'h2, 3'h3, 3'h6};
		exp_oe = 16'h0000;
		exp_oe[6] = FLOPPY_DMA_GATE_I;
		exp_oe[3] = (|SER1_IRQ_ENABLE_I) & SER1_AUX_OUTPUT_TWO_I;
		exp_oe[7] = PARALLEL_IRQ_GATE_I & ~(ecp & ECP_SERVICE_FLAG_I);
	endfunction : exp_oe

	task automatic end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim

	task automatic look;
		@(posedge CLK_I);
		#1;
	endtask : look

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_I);
		CFG_ADDR_I <= a;
		CFG_WDATA_I <= d;
		CFG_WR_I <= 1'b1;
		@(posedge CLK_I);
		CFG_WR_I <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge CLK_I);
		CFG_ADDR_I <= a;
		CFG_RD_I <= 1'b1;
		@(posedge CLK_I);
		CFG_RD_I <= 1'b0;
		#1;
		`CHK("cfg read", e, CFG_RDATA_O)
	endtask : rd

	task automatic io(input logic [15:0] a, input logic [7:0] e);
		@(posedge CLK_I);
		IO_ADDR_I <= a;
		IO_CYC_I <= 1'b1;
		look();
		`CHK("selects", e, sels)
	endtask : io

	task automatic cfg(input logic [7:0] ldn, input logic [7:0] hi, input logic [7:0] lo);
		wr(8'h07, ldn);
		wr(8'h60, hi);
		wr(8'h61, lo);
		wr(8'h30, 8'h01);
	endtask : cfg

	initial begin
		CLK_I = 1'b0;
		RESET_N_I = 1'b0;
		{CFG_WR_I, CFG_RD_I, IO_CYC_I, CFG_ADDR_I, CFG_WDATA_I, IO_ADDR_I} = 35'h0;
		`UNITS = 29'h0;
		ack_delay = 2'h0;
		n_fail = 0;
		checks = 0;
		cycles = 0;
		void'($urandom(64));
		repeat (8) @(posedge CLK_I);
		RESET_N_I <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(8'h07, dma_ldn[i]);
			rd(8'h74, 8'h04);
			rd(8'h70, 8'h00);
		end
		wr(8'h07, 8'h07);
		wr(8'h74, 8'h02);
		rd(8'h74, 8'h00);
		wr(8'h60, 8'h12);
		rd(8'h60, 8'h00);
		rd(8'h75, 8'h00);
		cfg(8'h00, 8'h03, 8'hF0);
		rd(8'h61, 8'hF0);
		rd(8'h60, 8'h03);
		wr(8'h70, 8'h06);
		wr(8'h74, 8'h02);
		@(posedge CLK_I);
		FLOPPY_IRQ_I <= 1'b1;
		FLOPPY_DREQ_I <= 1'b1;
		look();
		`CHK("irq oe", 16'h0000, IRQ_OE_O)
		`CHK("dma oe", 3'h0, DMA_REQUEST_PIN_OE_O)
		@(posedge CLK_I);
		FLOPPY_DMA_GATE_I <= 1'b1;
		ack_delay <= 2'h3;
		look();
		`CHK("irq oe", 16'h0040, IRQ_OE_O)
		`CHK("irq pins", 16'h0040, IRQ_O)
		`CHK("dma pins", 3'h2, DMA_REQUEST_PIN_O & DMA_REQUEST_PIN_OE_O)
		for (int k = 0; k < 10 && FLOPPY_DACK_O !== 1'b1; k++)
			look();
		`CHK("floppy dack", 1'b1, FLOPPY_DACK_O)
		`CHK("parallel dack", 1'b0, PAR_DACK_O)
		io(16'hA3F2, 8'h80);
		`CHK("offset", 3'h2, IO_OFFSET_O)
		io(16'h03F8, 8'h00);
		@(posedge CLK_I);
		SMI_EN_I <= 1'b0;
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 16; s++) begin
				@(posedge CLK_I);
				SERIAL_IRQ_MODE_I <= m[0];
				wr(8'h70, 8'(s));
				look();
				e16 = (s == 0) ? 16'h0000 : 16'h0001 << s;
				if (m == 0)
					e16 = e16 & 16'h1CF8;
				`CHK("irq oe", e16, IRQ_OE_O)
			end
		end
		wr(8'h70, 8'h06);
		for (int s = 0; s < 8; s++) begin
			wr(8'h74, 8'(s));
			look();
			e16 = (s >= 1 && s <= 3) ? 16'h0001 << (s - 1) : 16'h0000;
			`CHK("dma oe", e16[2:0], DMA_REQUEST_PIN_OE_O)
			rd(8'h74, 8'(s));
		end
		wr(8'h74, 8'h02);
		cfg(8'h04, 8'h02, 8'hF8);
		wr(8'h70, 8'h03);
		cfg(8'h03, 8'h03, 8'h78);
		wr(8'h70, 8'h07);
		wr(8'h74, 8'h03);
		for (int n = 0; n < 60; n++) begin
			@(posedge CLK_I);
			`UNITS <= 29'($urandom);
			ack_delay <= 2'($urandom);
			look();
			e16 = exp_oe();
			`CHK("irq oe", e16, IRQ_OE_O)
			`CHK("irq pins", e16 & {8'h00, PAR_IRQ_I, FLOPPY_IRQ_I, 2'b00, SER1_IRQ_I, 3'b000}, IRQ_O)
			`CHK("dma oe", {ECP_DMA_GATE_I, FLOPPY_DMA_GATE_I, 1'b0}, DMA_REQUEST_PIN_OE_O)
			`CHK("mgmt irq", ~(SMI_REQ_I & SMI_EN_I), SYS_MGMT_IRQ_N_O)
		end
		@(posedge CLK_I);
		`UNITS <= 29'h0;
		for (int k = 0; k < 8; k++)
			io(16'h0378 + 16'(k), 8'h40);
		io(16'h0778, 8'h20);
		io(16'h077A, 8'h20);
		io(16'h077B, 8'h00);
		wr(8'h61, 8'h7C);
		for (int k = 0; k < 4; k++)
			io(16'h037C + 16'(k), (k < 3) ? 8'h40 : 8'h00);
		io(16'h02FF, 8'h10);
		wr(8'h07, 8'h04);
		wr(8'h61, 8'hFC);
		io(16'h02FC, 8'h00);
		wr(8'h60, 8'h00);
		wr(8'h61, 8'h80);
		io(16'h0080, 8'h00);
		cfg(8'h05, 8'h00, 8'h00);
		wr(8'h62, 8'h02);
		wr(8'h63, 8'hE8);
		rd(8'h63, 8'hE8);
		io(16'h02EF, 8'h04);
		`CHK("offset", 3'h7, IO_OFFSET_O)
		wr(8'h60, 8'h03);
		wr(8'h61, 8'hE8);
		io(16'h03EA, 8'h08);
		wr(8'h74, 8'h01);
		@(posedge CLK_I);
		SER2_DMA_GATE_I <= 1'b1;
		SER2_DREQ_I <= 1'b1;
		look();
		`CHK("dma pins", 3'h1, DMA_REQUEST_PIN_O & DMA_REQUEST_PIN_OE_O)
		for (int k = 0; k < 10 && SER2_DACK_O !== 1'b1; k++)
			look();
		`CHK("serial two dack", 1'b1, SER2_DACK_O)
		wr(8'h07, 8'h07);
		wr(8'h30, 8'h01);
		io(16'h1060, 8'h02);
		io(16'h0064, 8'h01);
		io(16'h0061, 8'h00);
		wr(8'h70, 8'h0C);
		@(posedge CLK_I);
		KBD_IRQ_I <= 1'b1;
		look();
		`CHK("irq pins", 16'h1000, IRQ_O)
		@(posedge CLK_I);
		FLOPPY_DMA_GATE_I <= 1'b1;
		wr(8'h07, 8'h00);
		wr(8'h30, 8'h00);
		io(16'h03F1, 8'h00);
		`CHK("irq oe", 16'h0000, IRQ_OE_O & 16'h0040)
		end_sim();
	end
endmodule : testbench
